//--- inc/swe_pkg.sv
// shared constants of the single wire eeprom command unit
package swe_pkg;
	localparam int BYTE_W = 8;
	localparam int DATA_BYTES = 32;
	localparam int APP_BYTES = 8;
	localparam int ROM_BITS = 64;
	localparam int FIFO_DEPTH = 16;
	// rom selection commands
	localparam logic [7:0] ROM_READ = 8'h33;
	localparam logic [7:0] ROM_MATCH = 8'h55;
	localparam logic [7:0] ROM_SKIP = 8'hcc;
	localparam logic [7:0] ROM_SEARCH = 8'hf0;
	// memory function commands
	localparam logic [7:0] FN_WR_SCR = 8'h0f;
	localparam logic [7:0] FN_RD_SCR = 8'haa;
	localparam logic [7:0] FN_CP_SCR = 8'h55;
	localparam logic [7:0] FN_RD_MEM = 8'hf0;
	localparam logic [7:0] FN_WR_APP = 8'h99;
	localparam logic [7:0] FN_RD_STAT = 8'h66;
	localparam logic [7:0] FN_RD_APP = 8'hc3;
	localparam logic [7:0] FN_CP_LOCK = 8'h5a;
	// validation keys
	localparam logic [7:0] KEY_COPY = 8'ha5;
	localparam logic [7:0] KEY_STAT = 8'h00;
	// lock status byte values
	localparam logic [7:0] STAT_OPEN = 8'hff;
	localparam logic [7:0] STAT_LOCKED = 8'hfc;
	// eeprom program settle time
	localparam int PROG_TIME_US = 9000;
	localparam int CLK_MHZ = 100;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	// arbitrary identity value
	localparam logic [63:0] ROM_CODE_DEF = 64'h00a1_b2c3_d4e5_f601;

	typedef enum logic [2:0] {
		BS_IDLE,
		BS_ROMCMD,
		BS_READROM,
		BS_MATCHROM,
		BS_SEARCH,
		BS_FUNC
	} swe_bus_t;

	typedef enum logic [2:0] {
		FS_CMD,
		FS_ADDR,
		FS_WRDATA,
		FS_RDDATA,
		FS_KEY,
		FS_STATUS,
		FS_HALT
	} swe_fn_t;
endpackage

//--- rtl/swe_fifo.sv
// byte fifo between bit assembler and command engine
`timescale 1ns/1ns
module swe_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             flush,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr_ff;
	logic [AW:0]      rdPtr_ff;
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	assign empty = (wrPtr_ff == rdPtr_ff);
	assign full = (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]) && !empty;
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[rdPtr_ff[AW-1:0]];
	assign push = inValid && !full;
	assign pop = outReady && !empty;

	always_ff @(posedge clk) begin
		if (push)
			mem[wrPtr_ff[AW-1:0]] <= inData;
	end

	always_ff @(posedge clk) begin
		if (srst || flush) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
		end else begin
			if (push)
				wrPtr_ff <= wrPtr_ff + 1'b1;
			if (pop)
				rdPtr_ff <= rdPtr_ff + 1'b1;
		end
	end
endmodule

//--- rtl/swe_cmd_unit.sv
// rom selection and memory function command layer
`timescale 1ns/1ns
// Function
// - read rom sends whole 64-bit code
// - match rom compares 64 bits, then function
// - mismatch idles until next bus reset
// - skip rom goes straight to function
// - search rom joins enumeration per bit
// - write scratchpad stores, increments, wraps 1Fh
// - read scratchpad returns bytes, wraps 1Fh
// - copy with key programs whole scratchpad
// - read memory loads eeprom, then reads
// - read memory load done even without address
// - write application fills 8-byte scratchpad, wraps
// - locked register discards application writes
// - status returned only after zero key
// - status low two bits zero when locked
// - read application wraps 8, source by lock
// - copy and lock copies and protects together
// - reset instead of key cancels lock
// - copy and lock succeeds only once
// - bus reset aborts any transfer
// - order reset, rom command, function command
// - rom commands are exactly 8 bits
// - status FFh unlocked, FCh locked
module swe_cmd_unit
	import swe_pkg::*;
#(
	parameter logic [63:0] ROM_CODE = swe_pkg::ROM_CODE_DEF,
	parameter int          PROG_CNT = swe_pkg::PROG_CYCLES,
	parameter int          FDEPTH = swe_pkg::FIFO_DEPTH
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic busReset,
	input  wire logic writeSlot,
	input  wire logic writeBit,
	input  wire logic readSlot,
	output logic      readBit,
	output logic      readBitValid,
	output logic      progActive,
	output logic      appLocked,
	output logic      rxOverflow
);
	import swe_pkg::*;

	localparam int PCW = $clog2(PROG_CNT + 1);

	swe_bus_t   busState_ff;
	swe_fn_t    fnState_ff;
	logic [7:0] rxShift_ff;
	logic [2:0] rxCnt_ff;
	logic [5:0] romBit_ff;
	logic [1:0] srchPh_ff;
	logic       pendValid_ff;
	logic [7:0] pendByte_ff;
	logic       ovf_ff;
	logic [7:0] txShift_ff;
	logic [3:0] txCnt_ff;
	logic       readBit_ff;
	logic       readBitValid_ff;
	logic [7:0] cmd_ff;
	logic [4:0] addr_ff;
	logic       locked_ff;
	logic [PCW-1:0] progCnt_ff;
	logic       progActive_ff;

	logic [7:0] scratch [DATA_BYTES];
	logic [7:0] eeprom  [DATA_BYTES];
	logic [7:0] appScr  [APP_BYTES];
	logic [7:0] appReg  [APP_BYTES];

	logic [7:0] rxByte;
	logic       byteDone;
	logic       romBitVal;
	logic       fifoInReady;
	logic       fifoOutValid;
	logic [7:0] fifoOutData;
	logic       engReady;
	logic       engTake;
	logic       txLoad;
	logic [7:0] txByte;
	logic       doLoadMem;
	logic       doCopyScr;
	logic       doCopyApp;
	logic [7:0] statByte;

	assign rxByte = {writeBit, rxShift_ff[7:1]};
	assign byteDone = writeSlot && (rxCnt_ff == 3'd7);
	assign romBitVal = ROM_CODE[romBit_ff];
	assign statByte = locked_ff ? STAT_LOCKED : STAT_OPEN;

	// bit assembler and rom phase
	always_ff @(posedge clk) begin
		if (srst) begin
			busState_ff <= BS_IDLE;
			rxShift_ff <= 8'h00;
			rxCnt_ff <= 3'd0;
			romBit_ff <= 6'd0;
			srchPh_ff <= 2'd0;
		end else if (busReset) begin
			busState_ff <= BS_ROMCMD;
			rxCnt_ff <= 3'd0;
			romBit_ff <= 6'd0;
			srchPh_ff <= 2'd0;
		end else begin
			if (writeSlot) begin
				rxShift_ff <= rxByte;
				rxCnt_ff <= rxCnt_ff + 3'd1;
			end
			unique case (busState_ff)
				BS_IDLE: begin
				end
				BS_ROMCMD: begin
					if (byteDone) begin
						if (rxByte == ROM_READ)
							busState_ff <= BS_READROM;
						else if (rxByte == ROM_MATCH)
							busState_ff <= BS_MATCHROM;
						else if (rxByte == ROM_SKIP)
							busState_ff <= BS_FUNC;
						else if (rxByte == ROM_SEARCH)
							busState_ff <= BS_SEARCH;
						else
							busState_ff <= BS_IDLE;
					end
				end
				BS_READROM: begin
					if (readSlot) begin
						romBit_ff <= romBit_ff + 6'd1;
						if (romBit_ff == 6'd63)
							busState_ff <= BS_FUNC;
					end
				end
				BS_MATCHROM: begin
					if (writeSlot) begin
						romBit_ff <= romBit_ff + 6'd1;
						if (writeBit != romBitVal)
							busState_ff <= BS_IDLE;
						else if (romBit_ff == 6'd63)
							busState_ff <= BS_FUNC;
					end
				end
				BS_SEARCH: begin
					if (readSlot && srchPh_ff != 2'd2)
						srchPh_ff <= srchPh_ff + 2'd1;
					if (writeSlot && srchPh_ff == 2'd2) begin
						srchPh_ff <= 2'd0;
						romBit_ff <= romBit_ff + 6'd1;
						if (writeBit != romBitVal)
							busState_ff <= BS_IDLE;
						else if (romBit_ff == 6'd63)
							busState_ff <= BS_FUNC;
					end
				end
				BS_FUNC: begin
				end
			endcase
			if (busState_ff != BS_ROMCMD && busState_ff != BS_FUNC)
				rxCnt_ff <= 3'd0;
		end
	end

	// completed function bytes wait here for the fifo
	always_ff @(posedge clk) begin
		if (srst || busReset) begin
			pendValid_ff <= 1'b0;
			pendByte_ff <= 8'h00;
			ovf_ff <= 1'b0;
		end else begin
			if (pendValid_ff && fifoInReady)
				pendValid_ff <= 1'b0;
			if (byteDone && busState_ff == BS_FUNC) begin
				pendByte_ff <= rxByte;
				pendValid_ff <= 1'b1;
				if (pendValid_ff && !fifoInReady)
					ovf_ff <= 1'b1;
			end
		end
	end

	swe_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FDEPTH)
	) u_fifo (
		.clk      (clk),
		.srst     (srst),
		.flush    (busReset),
		.inValid  (pendValid_ff),
		.inReady  (fifoInReady),
		.inData   (pendByte_ff),
		.outValid (fifoOutValid),
		.outReady (engReady),
		.outData  (fifoOutData)
	);

	// engine stalls the fifo while eeprom programs
	assign engReady = !progActive_ff;
	assign engTake = fifoOutValid && engReady;
	assign txLoad = (busState_ff == BS_FUNC) && (txCnt_ff == 4'd0)
		&& (fnState_ff == FS_RDDATA || fnState_ff == FS_STATUS)
		&& !busReset;

	always_comb begin
		txByte = statByte;
		if (fnState_ff == FS_RDDATA) begin
			if (cmd_ff == FN_RD_APP)
				txByte = locked_ff ? appReg[addr_ff[2:0]]
					: appScr[addr_ff[2:0]];
			else
				txByte = scratch[addr_ff];
		end
	end

	assign doLoadMem = engTake && fnState_ff == FS_CMD
		&& fifoOutData == FN_RD_MEM;
	assign doCopyScr = engTake && fnState_ff == FS_KEY
		&& cmd_ff == FN_CP_SCR && fifoOutData == KEY_COPY;
	assign doCopyApp = engTake && fnState_ff == FS_KEY && !locked_ff
		&& cmd_ff == FN_CP_LOCK && fifoOutData == KEY_COPY;

	// function command engine
	always_ff @(posedge clk) begin
		if (srst || busReset) begin
			fnState_ff <= FS_CMD;
			cmd_ff <= 8'h00;
			addr_ff <= 5'd0;
		end else begin
			if (txLoad)
				addr_ff <= addr_ff + 5'd1;
			if (engTake) begin
				unique case (fnState_ff)
					FS_CMD: begin
						cmd_ff <= fifoOutData;
						unique case (fifoOutData)
							FN_WR_SCR, FN_RD_SCR, FN_RD_MEM,
							FN_WR_APP, FN_RD_APP:
								fnState_ff <= FS_ADDR;
							FN_CP_SCR, FN_CP_LOCK, FN_RD_STAT:
								fnState_ff <= FS_KEY;
							default:
								fnState_ff <= FS_HALT;
						endcase
					end
					FS_ADDR: begin
						addr_ff <= fifoOutData[4:0];
						if (cmd_ff == FN_WR_SCR || cmd_ff == FN_WR_APP)
							fnState_ff <= FS_WRDATA;
						else
							fnState_ff <= FS_RDDATA;
					end
					FS_WRDATA: begin
						addr_ff <= addr_ff + 5'd1;
					end
					FS_KEY: begin
						if (cmd_ff == FN_RD_STAT && fifoOutData == KEY_STAT)
							fnState_ff <= FS_STATUS;
						else
							fnState_ff <= FS_HALT;
					end
					FS_RDDATA, FS_STATUS, FS_HALT: begin
					end
				endcase
			end
		end
	end

	// scratchpad, eeprom and application storage
	always_ff @(posedge clk) begin
		if (engTake && fnState_ff == FS_WRDATA) begin
			if (cmd_ff == FN_WR_SCR)
				scratch[addr_ff] <= fifoOutData;
			else if (!locked_ff)
				appScr[addr_ff[2:0]] <= fifoOutData;
		end
		if (doLoadMem)
			scratch <= eeprom;
		if (doCopyScr)
			eeprom <= scratch;
		if (doCopyApp)
			appReg <= appScr;
	end

	always_ff @(posedge clk) begin
		if (srst)
			locked_ff <= 1'b0;
		else if (doCopyApp)
			locked_ff <= 1'b1;
	end

	// program timer; master keeps the line up meanwhile
	always_ff @(posedge clk) begin
		if (srst) begin
			progCnt_ff <= '0;
			progActive_ff <= 1'b0;
		end else if (doCopyScr || doCopyApp) begin
			progCnt_ff <= PCW'(PROG_CNT - 1);
			progActive_ff <= 1'b1;
		end else if (progCnt_ff != '0) begin
			progCnt_ff <= progCnt_ff - 1'b1;
		end else begin
			progActive_ff <= 1'b0;
		end
	end

	// transmit byte register, shifted out lsb first
	always_ff @(posedge clk) begin
		if (srst || busReset) begin
			txShift_ff <= 8'hff;
			txCnt_ff <= 4'd0;
		end else if (txLoad) begin
			txShift_ff <= txByte;
			txCnt_ff <= 4'd8;
		end else if (readSlot && busState_ff == BS_FUNC
			&& txCnt_ff != 4'd0) begin
			txShift_ff <= {1'b1, txShift_ff[7:1]};
			txCnt_ff <= txCnt_ff - 4'd1;
		end
	end

	// answer to read slots in rom read, search and function phases
	always_ff @(posedge clk) begin
		if (srst || busReset) begin
			readBit_ff <= 1'b1;
			readBitValid_ff <= 1'b0;
		end else begin
			readBitValid_ff <= 1'b0;
			if (readSlot) begin
				unique case (busState_ff)
					BS_READROM: begin
						readBit_ff <= romBitVal;
						readBitValid_ff <= 1'b1;
					end
					BS_SEARCH: begin
						if (srchPh_ff != 2'd2) begin
							readBit_ff <= romBitVal ^ srchPh_ff[0];
							readBitValid_ff <= 1'b1;
						end
					end
					BS_FUNC: begin
						if (txCnt_ff != 4'd0) begin
							readBit_ff <= txShift_ff[0];
							readBitValid_ff <= 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	assign readBit = readBit_ff;
	assign readBitValid = readBitValid_ff;
	assign progActive = progActive_ff;
	assign appLocked = locked_ff;
	assign rxOverflow = ovf_ff;
endmodule

//--- bench/swe_cmd_unit_sva.sv
// assertion checker for the command unit
`timescale 1ns/1ns
module swe_cmd_unit_sva #(
	parameter int PROG_CNT = 20
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic busReset,
	input wire logic readSlot,
	input wire logic readBitValid,
	input wire logic progActive,
	input wire logic appLocked,
	input wire logic rxOverflow
);
	int progCnt_ff;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// cycles spent programming so far
	always_ff @(posedge clk) begin
		if (srst || !progActive)
			progCnt_ff <= 0;
		else
			progCnt_ff <= progCnt_ff + 1;
	end
	AST_RST_QUIET: assert property ($fell(srst) |-> !progActive && !appLocked
		&& !rxOverflow && !readBitValid) else $error("outputs busy after reset");
	AST_ANSWER_CAUSE: assert property (readBitValid |-> $past(readSlot))
		else $error("answer without read slot");
	AST_ROM_SILENT: assert property (busReset |=> !readBitValid [*8])
		else $error("answer during rom command");
	AST_LOCK_ONCE: assert property (appLocked |=> appLocked)
		else $error("lock released");
	AST_LOCK_PROG: assert property ($rose(appLocked) |-> $rose(progActive))
		else $error("lock without programming");
	AST_PROG_LEN: assert property ($fell(progActive) && !$past(srst) |->
		progCnt_ff == PROG_CNT) else $error("program time wrong");
	AST_PROG_BOUND: assert property (progActive |-> progCnt_ff < PROG_CNT)
		else $error("program time overrun");
	AST_OVF_HOLD: assert property (rxOverflow && !busReset |=> rxOverflow)
		else $error("overflow flag lost");
endmodule

bind swe_cmd_unit swe_cmd_unit_sva #(.PROG_CNT(PROG_CNT)) chk (
	.clk(clk),
	.srst(srst),
	.busReset(busReset),
	.readSlot(readSlot),
	.readBitValid(readBitValid),
	.progActive(progActive),
	.appLocked(appLocked),
	.rxOverflow(rxOverflow)
);

//--- bench/swe_master_model.sv
// bus master model driving reset and bit slots
`timescale 1ns/1ns
module swe_master_model (
	input  wire logic clk,
	input  wire logic readBit,
	input  wire logic readBitValid,
	input  wire logic progActive,
	output logic      busReset,
	output logic      writeSlot,
	output logic      writeBit,
	output logic      readSlot
);
	logic heard;
	initial begin
		busReset = 1'b0;
		writeSlot = 1'b0;
		writeBit = 1'b0;
		readSlot = 1'b0;
		heard = 1'b0;
	end
	task automatic pulseReset();
		repeat (6) @(posedge clk);
		// line kept quiet while the device programs
		while (progActive) @(posedge clk);
		busReset <= 1'b1;
		@(posedge clk);
		busReset <= 1'b0;
	endtask
	task automatic sendBit(input logic v);
		@(posedge clk);
		writeSlot <= 1'b1;
		writeBit <= v;
		@(posedge clk);
		writeSlot <= 1'b0;
	endtask
	task automatic recvBit(output logic v);
		@(posedge clk);
		readSlot <= 1'b1;
		@(posedge clk);
		readSlot <= 1'b0;
		@(negedge clk);
		// released line is pulled up
		v = readBitValid ? readBit : 1'b1;
		heard |= readBitValid;
	endtask
	task automatic sendByte(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			sendBit(b[i]);
	endtask
	task automatic recvByte(output logic [7:0] b);
		heard = 1'b0;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 8; i++)
			recvBit(b[i]);
	endtask
endmodule

//--- bench/swe_cmd_unit_bench.sv
// self-checking bench for the command unit
`timescale 1ns/1ns
module swe_cmd_unit_bench;
	import swe_pkg::*;
	// long enough for a burst of bytes to pile up while programming
	localparam int PCNT = 400;
	logic       clk;
	logic       srst;
	wire        busReset;
	wire        writeSlot;
	wire        writeBit;
	wire        readSlot;
	wire        readBit;
	wire        readBitValid;
	wire        progActive;
	wire        appLocked;
	wire        rxOverflow;
	logic       b0;
	logic       b1;
	logic [7:0] scr [32], eep [32], apS [8], apR [8], got;
	int         failures, cmp_count;
	swe_cmd_unit #(
		.PROG_CNT (PCNT)
	) uut (
		.clk          (clk),
		.srst         (srst),
		.busReset     (busReset),
		.writeSlot    (writeSlot),
		.writeBit     (writeBit),
		.readSlot     (readSlot),
		.readBit      (readBit),
		.readBitValid (readBitValid),
		.progActive   (progActive),
		.appLocked    (appLocked),
		.rxOverflow   (rxOverflow)
	);
	swe_master_model m (
		.clk          (clk),
		.readBit      (readBit),
		.readBitValid (readBitValid),
		.progActive   (progActive),
		.busReset     (busReset),
		.writeSlot    (writeSlot),
		.writeBit     (writeBit),
		.readSlot     (readSlot)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rdChk(input logic [7:0] e);
		m.recvByte(got);
		chk(got, e);
	endtask
	task automatic mute();
		m.recvByte(got);
		chk({7'h0, m.heard}, 8'h00);
	endtask
	task automatic sel();
		m.pulseReset();
		m.sendByte(ROM_SKIP);
	endtask
	task automatic op(input logic [7:0] f);
		sel();
		m.sendByte(f);
	endtask
	task automatic stat(input logic [7:0] e);
		m.sendByte(FN_RD_STAT);
		m.sendByte(KEY_STAT);
		rdChk(e);
	endtask
	task automatic match(input logic [63:0] c);
		m.pulseReset();
		m.sendByte(ROM_MATCH);
		for (int k = 0; k < 8; k++)
			m.sendByte(c[8*k +: 8]);
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		report_and_stop();
	end
	initial begin
		srst = 1'b1;
		failures = 0;
		cmp_count = 0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		// no bus reset seen yet: whole transaction must be ignored
		m.sendByte(ROM_SKIP);
		m.sendByte(FN_RD_STAT);
		m.sendByte(KEY_STAT);
		mute();
		sel();
		stat(STAT_OPEN);
		$display("status done");
		op(FN_WR_SCR);
		m.sendByte(8'h1e);
		for (int k = 0; k < 34; k++) begin
			scr[(30 + k) % 32] = 8'h40 + k[7:0];
			m.sendByte(8'h40 + k[7:0]);
		end
		op(FN_RD_SCR);
		m.sendByte(8'h1f);
		for (int k = 0; k < 33; k++)
			rdChk(scr[(31 + k) % 32]);
		op(FN_CP_SCR);
		m.sendByte(KEY_COPY);
		eep = scr;
		// bytes sent while programming pile up until one is lost
		for (int k = 0; k < 18; k++)
			m.sendByte(8'h00);
		repeat (2) @(posedge clk);
		chk({7'h0, rxOverflow}, 8'h01);
		op(FN_WR_SCR);
		m.sendByte(8'h00);
		m.sendByte(8'h99);
		op(FN_RD_MEM);
		op(FN_RD_SCR);
		m.sendByte(8'h00);
		for (int k = 0; k < 32; k++)
			rdChk(eep[k]);
		op(FN_RD_MEM);
		m.sendByte(8'h1f);
		rdChk(eep[31]);
		rdChk(eep[0]);
		$display("memory done");
		m.pulseReset();
		m.sendByte(ROM_READ);
		for (int k = 0; k < 8; k++)
			rdChk(ROM_CODE_DEF[8*k +: 8]);
		stat(STAT_OPEN);
		match(ROM_CODE_DEF);
		stat(STAT_OPEN);
		match(ROM_CODE_DEF ^ 64'h8000_0000_0000_0000);
		m.sendByte(FN_RD_STAT);
		m.sendByte(KEY_STAT);
		mute();
		m.pulseReset();
		m.sendByte(ROM_SEARCH);
		for (int k = 0; k < 64; k++) begin
			m.recvBit(b0);
			m.recvBit(b1);
			chk({6'h0, b0, b1}, {6'h0, ROM_CODE_DEF[k], ~ROM_CODE_DEF[k]});
			m.sendBit(b0);
		end
		stat(STAT_OPEN);
		op(8'h3c);
		mute();
		op(FN_RD_STAT);
		m.sendByte(8'h01);
		mute();
		$display("rom done");
		op(FN_WR_APP);
		m.sendByte(8'h06);
		for (int k = 0; k < 9; k++) begin
			apS[(6 + k) % 8] = 8'h80 + k[7:0];
			m.sendByte(8'h80 + k[7:0]);
		end
		op(FN_RD_APP);
		m.sendByte(8'h07);
		for (int k = 0; k < 9; k++)
			rdChk(apS[(7 + k) % 8]);
		op(FN_CP_LOCK);
		sel();
		stat(STAT_OPEN);
		op(FN_CP_LOCK);
		m.sendByte(KEY_COPY);
		apR = apS;
		sel();
		stat(STAT_LOCKED);
		chk({7'h0, appLocked}, 8'h01);
		op(FN_WR_APP);
		m.sendByte(8'h00);
		m.sendByte(8'h55);
		op(FN_CP_LOCK);
		m.sendByte(KEY_COPY);
		repeat (8) @(posedge clk);
		chk({7'h0, progActive}, 8'h00);
		op(FN_RD_APP);
		m.sendByte(8'h00);
		for (int k = 0; k < 8; k++)
			rdChk(apR[k]);
		chk({7'h0, rxOverflow}, 8'h00);
		$display("application done");
		report_and_stop();
	end
endmodule
